// ===== tb.sv
// self-checking bench for the true dual-port memory
`timescale 1ns/10ps
module tb;
    localparam int DW = tdpr_pkg::DATA_W;
    localparam int AW = tdpr_pkg::ADDR_W;
    localparam logic [DW-1:0] IMG_WORD = DW'(16'h5a3c);
    // start-up image: one-dimensional, exactly one entry per word
    localparam logic [DW-1:0] IMG [tdpr_pkg::WORDS] = '{default: IMG_WORD};

    typedef struct packed {
        logic          v;
        logic          rx;
        logic [DW-1:0] a;
        logic [DW-1:0] b;
        logic [DW-1:0] ia;
        logic [DW-1:0] ib;
    } tdpr_exp_t;

    logic          clk;
    logic          reset_n;
    logic          ena;
    logic [DW-1:0] data_a;
    logic [AW-1:0] addr_a;
    logic          wren_a;
    logic [DW-1:0] data_b;
    logic [AW-1:0] addr_b;
    logic          wren_b;
    logic [DW-1:0] q_a;
    logic [DW-1:0] q_b;
    logic          q_a_sign;
    logic          q_b_sign;
    logic [DW-1:0] qr_a;
    logic [DW-1:0] qr_b;
    logic          qr_a_sign;
    logic          qr_b_sign;
    logic [DW-1:0] qi_a;
    logic [DW-1:0] qi_b;
    logic [DW-1:0] ref_mem [tdpr_pkg::WORDS];
    logic [DW-1:0] ref_img [tdpr_pkg::WORDS];
    tdpr_exp_t     pipe [3];
    int            n_mismatch;
    int            check_count;

    ////////////////////////////////////////////////////////////////////////////
    tdpr_user i_tdpr_user (.ena(ena), .data_a(data_a), .addr_a(addr_a), .wren_a(wren_a),
        .data_b(data_b), .addr_b(addr_b), .wren_b(wren_b));

    tdpr_top #(.USE_ENABLE(1'b1)) i_tdpr_top (.clk(clk), .reset_n(reset_n), .ena(ena),
        .data_a(data_a), .addr_a(addr_a), .wren_a(wren_a), .data_b(data_b), .addr_b(addr_b),
        .wren_b(wren_b), .q_a(q_a), .q_b(q_b), .q_a_sign(q_a_sign), .q_b_sign(q_b_sign));

    // relaxed plus output register: same latency as the default build
    tdpr_top #(.REGISTER_OUTPUT(1'b1), .RELAXED_COLLISION_OPTION(1'b1), .USE_ENABLE(1'b1))
        i_tdpr_top_r (.clk(clk), .reset_n(reset_n), .ena(ena), .data_a(data_a),
        .addr_a(addr_a), .wren_a(wren_a), .data_b(data_b), .addr_b(addr_b), .wren_b(wren_b),
        .q_a(qr_a), .q_b(qr_b), .q_a_sign(qr_a_sign), .q_b_sign(qr_b_sign));

    // start-up image build, otherwise the same as the default build
    tdpr_top #(.USE_ENABLE(1'b1), .USE_INIT(1'b1), .INIT_IMAGE(IMG)) i_tdpr_top_i (.clk(clk),
        .reset_n(reset_n), .ena(ena), .data_a(data_a), .addr_a(addr_a), .wren_a(wren_a),
        .data_b(data_b), .addr_b(addr_b), .wren_b(wren_b), .q_a(qi_a), .q_b(qi_b),
        .q_a_sign(), .q_b_sign());

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic wrap_up();
        if (n_mismatch == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic [DW:0] got, input logic [DW:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR %0t read %h expected %h", $time, got, exp);
        end
    endtask

    // drive one cycle, model it, then check the word captured two qualified edges before
    task automatic step(input logic en, input logic wa, input logic [AW-1:0] aa,
                        input logic [DW-1:0] da, input logic wb, input logic [AW-1:0] ab,
                        input logic [DW-1:0] db);
        tdpr_exp_t e;
        e.v  = 1'b1;
        e.rx = wa || wb;
        e.a  = ref_mem[aa];
        e.b  = ref_mem[ab];
        e.ia = ref_img[aa];
        e.ib = ref_img[ab];
        i_tdpr_user.drive(en, wa, aa, da, wb, ab, db);
        if (en)
        begin
            if (wa)
            begin
                ref_mem[aa] = da;
                ref_img[aa] = da;
            end
            if (wb && !(wa && (aa == ab)))
            begin
                ref_mem[ab] = db;
                ref_img[ab] = db;
            end
            pipe[2] = pipe[1];
            pipe[1] = pipe[0];
            pipe[0] = e;
        end
        @(posedge clk);
        #1;
        if (pipe[2].v)
        begin
            chk({q_a_sign, q_a}, {pipe[2].a[tdpr_pkg::SIGN_POS], pipe[2].a});
            chk({q_b_sign, q_b}, {pipe[2].b[tdpr_pkg::SIGN_POS], pipe[2].b});
            chk({1'b0, qi_a}, {1'b0, pipe[2].ia});
            chk({1'b0, qi_b}, {1'b0, pipe[2].ib});
            if (en && !pipe[2].rx)
            begin
                chk({qr_a_sign, qr_a}, {pipe[2].a[tdpr_pkg::SIGN_POS], pipe[2].a});
                chk({qr_b_sign, qr_b}, {pipe[2].b[tdpr_pkg::SIGN_POS], pipe[2].b});
            end
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (2000) @(posedge clk);
        n_mismatch++;
        wrap_up();
    end

    initial
    begin
        reset_n     = 1'b0;
        n_mismatch  = 0;
        check_count = 0;
        foreach (ref_mem[i])
            ref_mem[i] = '0;
        foreach (ref_img[i])
            ref_img[i] = IMG_WORD;
        foreach (pipe[i])
            pipe[i] = '0;
        repeat (4) @(posedge clk);
        #1;
        reset_n = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        // untouched words at both ends of the range read as zero, and as IMG_WORD in the image build
        step(1'b1, 1'b0, 8'h00, '0, 1'b0, 8'hff, '0);
        // both ports write every cycle
        for (int i = 0; i < 16; i++)
            step(1'b1, 1'b1, AW'(i), DW'(16'ha5c3 ^ (i * 16'h1111)),
                 1'b1, AW'(255 - i), DW'(16'h3c5a + (i * 16'h0f01)));
        // read back straight and crossed
        for (int i = 0; i < 16; i++)
            step(1'b1, 1'b0, AW'(i), '0, 1'b0, AW'(255 - i), '0);
        for (int i = 0; i < 16; i++)
            step(1'b1, 1'b0, AW'(255 - i), '0, 1'b0, AW'(i), '0);
        // read during write on the same and on the other port gives the old word in the default and image builds
        step(1'b1, 1'b1, 8'h03, 16'h7e81, 1'b0, 8'h03, '0);
        step(1'b1, 1'b0, 8'h03, '0, 1'b1, 8'h03, 16'hc018);
        step(1'b1, 1'b0, 8'h03, '0, 1'b0, 8'h03, '0);
        // qualifier low: no write, default and image build outputs hold
        step(1'b0, 1'b1, 8'h04, 16'hdead, 1'b1, 8'h05, 16'hbeef);
        step(1'b0, 1'b1, 8'h04, 16'hdead, 1'b1, 8'h05, 16'hbeef);
        step(1'b1, 1'b0, 8'h04, '0, 1'b0, 8'h05, '0);
        step(1'b1, 1'b1, 8'h80, 16'h8000, 1'b1, 8'h7f, 16'h7fff);
        step(1'b1, 1'b0, 8'h80, '0, 1'b0, 8'h7f, '0);
        for (int i = 0; i < 3; i++)
            step(1'b1, 1'b0, 8'h00, '0, 1'b0, 8'h00, '0);
        wrap_up();
    end

endmodule // tb

// ===== tdpr_mem.sv
// storage array with two read/write ports and registered read data
`timescale 1ns/10ps
module tdpr_mem #(
    parameter bit                          RELAXED   = 1'b0,
    parameter bit                          USE_INIT  = 1'b0,
    parameter logic [tdpr_pkg::DATA_W-1:0] INIT_IMAGE [tdpr_pkg::WORDS] = '{default: '0}
) (
    input  wire logic clk,
    input  wire logic rst_n,
    tdpr_port_if.mem  pa,
    tdpr_port_if.mem  pb
);

    typedef logic [tdpr_pkg::DATA_W-1:0] tdpr_image_t [tdpr_pkg::WORDS];

    ////////////////////////////////////////////////////////////////////////////
    // start-up contents, placed through the low ADDR_W bits of the image address
    function automatic tdpr_image_t start_image();
        tdpr_image_t                   img;
        logic [tdpr_pkg::IMAGE_AW-1:0] ia;
        for (int i = 0; i < tdpr_pkg::WORDS; i++)
        begin
            ia = i[tdpr_pkg::IMAGE_AW-1:0];                              // RQ6
            img[ia[tdpr_pkg::ADDR_W-1:0]] = tdpr_pkg::DATA_RESET;        // RQ5
            if (USE_INIT)
            begin
                img[ia[tdpr_pkg::ADDR_W-1:0]] = INIT_IMAGE[i];           // RQ5
            end
        end
        return img;
    endfunction

    // initialised here so that only the write process ever assigns the array
    tdpr_image_t                 store = start_image();
    logic [tdpr_pkg::DATA_W-1:0] next_rdata_a;
    logic [tdpr_pkg::DATA_W-1:0] next_rdata_b;
    logic [tdpr_pkg::DATA_W-1:0] old_word_a;
    logic [tdpr_pkg::DATA_W-1:0] old_word_b;

    ////////////////////////////////////////////////////////////////////////////
    // array writes, port b last
    always_ff @(posedge clk)
    begin
        if (pa.en && pa.we)
        begin
            store[pa.addr] <= pa.wdata;                              // RQ15
        end
        if (pb.en && pb.we)
        begin
            store[pb.addr] <= pb.wdata;                              // RQ15
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data
    always_comb
    begin
        old_word_a   = store[pa.addr];
        old_word_b   = store[pb.addr];
        next_rdata_a = pa.rdata;
        next_rdata_b = pb.rdata;
        if (pa.en)
        begin
            next_rdata_a = (RELAXED && pa.we) ? pa.wdata : old_word_a;     // RQ3 RQ4
        end
        if (pb.en)
        begin
            next_rdata_b = (RELAXED && pb.we) ? pb.wdata : old_word_b;     // RQ3 RQ4
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pa.rdata <= tdpr_pkg::DATA_RESET;
            pb.rdata <= tdpr_pkg::DATA_RESET;
        end
        else
        begin
            pa.rdata <= next_rdata_a;
            pb.rdata <= next_rdata_b;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    rd_old_word_a: assert property (@(posedge clk) disable iff (!rst_n)   // RQ3
        (!RELAXED && pa.en && pa.we) |=> pa.rdata == $past(old_word_a))
        else $error("collision read did not return old word");

    wr_store_a: assert property (@(posedge clk) disable iff (!rst_n)      // RQ15
        (pa.en && pa.we && !(pb.en && pb.we)) |=> store[$past(pa.addr)] == $past(pa.wdata))
        else $error("port a write not stored");

    rd_relaxed_a: assert property (@(posedge clk) disable iff (!rst_n)    // RQ4
        (RELAXED && pb.en && !pb.we) ##1 (pb.en && !pb.we) |=> pb.rdata == $past(old_word_b))
        else $error("relaxed read of port b wrong");

endmodule // tdpr_mem

// ===== tdpr_pkg.sv
// constants and types shared by the true dual-port memory
//
// What this block does
// RQ1: two independent ports a and b
// RQ2: inputs always registered; output register optional
// RQ3: default collision read returns old word
// RQ4: relaxed option: single register, collision undefined
// RQ5: contents zero unless initial image given
// RQ6: image words indexed by 32-bit address
// RQ7: user array one-dimensional, within word count
// RQ8: user presents addresses as unsigned numbers
// RQ9: qualifier gates memory, not output register
// RQ10: qualifier optional, shared by both ports
// RQ11: user never writes one address twice
// RQ12: depth parameter at least one, sets width
// RQ13: signed, unsigned or fractional word formats
// RQ14: signed formats carry sign in top bit
// RQ15: enabled write stores word, port reads
package tdpr_pkg;

    typedef enum {tdpr_signed_int, tdpr_unsigned_int, tdpr_signed_frac} tdpr_format_t;

    localparam tdpr_format_t FORMAT    = tdpr_signed_frac;
    localparam int           WORDS     = 256;                       // RQ12
    localparam int           INT_BITS  = 8;
    localparam int           FRAC_REQ  = 8;
    localparam int           IMAGE_AW  = 32;                        // RQ6

    // fractional bits only count for signed fractional
    function automatic int frac_bits(input tdpr_format_t f, input int r);
        return (f == tdpr_signed_frac) ? r : 0;                      // RQ13
    endfunction

    function automatic bit is_signed(input tdpr_format_t f);
        return f != tdpr_unsigned_int;                               // RQ14
    endfunction

    localparam int FRAC_BITS = frac_bits(FORMAT, FRAC_REQ);
    localparam int DATA_W    = INT_BITS + FRAC_BITS;                 // RQ14
    localparam int ADDR_W    = (WORDS > 1) ? $clog2(WORDS) : 1;      // RQ12
    localparam int SIGN_POS  = DATA_W - 1;

    localparam logic [DATA_W-1:0] DATA_RESET = '0;
    localparam logic [ADDR_W-1:0] ADDR_RESET = '0;
    localparam logic [1:0]        SYNC_RESET = 2'h0;

endpackage

// ===== tdpr_port_if.sv
// one memory port between the control logic and the storage array
`timescale 1ns/10ps
interface tdpr_port_if;
    logic                          en;
    logic                          we;
    logic [tdpr_pkg::ADDR_W-1:0]   addr;
    logic [tdpr_pkg::DATA_W-1:0]   wdata;
    logic [tdpr_pkg::DATA_W-1:0]   rdata;

    modport ctrl (output en, output we, output addr, output wdata, input rdata);
    modport mem  (input en, input we, input addr, input wdata, output rdata);
endinterface

// ===== tdpr_top.sv
// true dual-port memory: input registers, read pipeline, optional output register
`timescale 1ns/10ps
module tdpr_top #(
    parameter bit                          REGISTER_OUTPUT          = 1'b0,
    parameter bit                          RELAXED_COLLISION_OPTION = 1'b0,
    parameter bit                          USE_ENABLE               = 1'b0,
    parameter bit                          USE_INIT                 = 1'b0,
    parameter logic [tdpr_pkg::DATA_W-1:0] INIT_IMAGE [tdpr_pkg::WORDS] = '{default: '0}
) (
    input  wire logic                          clk,
    input  wire logic                          reset_n,
    input  wire logic                          ena,
    input  wire logic [tdpr_pkg::DATA_W-1:0]   data_a,
    input  wire logic [tdpr_pkg::ADDR_W-1:0]   addr_a,
    input  wire logic                          wren_a,
    input  wire logic [tdpr_pkg::DATA_W-1:0]   data_b,
    input  wire logic [tdpr_pkg::ADDR_W-1:0]   addr_b,
    input  wire logic                          wren_b,
    output logic      [tdpr_pkg::DATA_W-1:0]   q_a,
    output logic      [tdpr_pkg::DATA_W-1:0]   q_b,
    output logic                               q_a_sign,
    output logic                               q_b_sign
);

    logic [1:0]                  sync;
    logic                        rst_n;
    logic                        gate;
    logic                        in_we_a;
    logic                        in_we_b;
    logic [tdpr_pkg::ADDR_W-1:0] in_addr_a;
    logic [tdpr_pkg::ADDR_W-1:0] in_addr_b;
    logic [tdpr_pkg::DATA_W-1:0] in_data_a;
    logic [tdpr_pkg::DATA_W-1:0] in_data_b;
    logic                        next_in_we_a;
    logic                        next_in_we_b;
    logic [tdpr_pkg::ADDR_W-1:0] next_in_addr_a;
    logic [tdpr_pkg::ADDR_W-1:0] next_in_addr_b;
    logic [tdpr_pkg::DATA_W-1:0] next_in_data_a;
    logic [tdpr_pkg::DATA_W-1:0] next_in_data_b;
    logic [tdpr_pkg::DATA_W-1:0] hold_a;
    logic [tdpr_pkg::DATA_W-1:0] hold_b;
    logic [tdpr_pkg::DATA_W-1:0] next_hold_a;
    logic [tdpr_pkg::DATA_W-1:0] next_hold_b;
    logic [tdpr_pkg::DATA_W-1:0] src_a;
    logic [tdpr_pkg::DATA_W-1:0] src_b;
    logic [tdpr_pkg::DATA_W-1:0] out_a;
    logic [tdpr_pkg::DATA_W-1:0] out_b;

    tdpr_port_if port_a ();
    tdpr_port_if port_b ();

    ////////////////////////////////////////////////////////////////////////////
    // reset release
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sync <= tdpr_pkg::SYNC_RESET;
        end
        else
        begin
            sync <= {sync[0], 1'b1};
        end
    end

    assign rst_n = sync[1];
    assign gate  = USE_ENABLE ? ena : 1'b1;                           // RQ10

    ////////////////////////////////////////////////////////////////////////////
    // input register stage, both ports
    always_comb
    begin
        next_in_we_a   = in_we_a;
        next_in_we_b   = in_we_b;
        next_in_addr_a = in_addr_a;
        next_in_addr_b = in_addr_b;
        next_in_data_a = in_data_a;
        next_in_data_b = in_data_b;
        if (gate)                                                    // RQ9
        begin
            next_in_we_a   = wren_a;                                 // RQ1 RQ2
            next_in_we_b   = wren_b;
            next_in_addr_a = addr_a;
            next_in_addr_b = addr_b;
            next_in_data_a = data_a;
            next_in_data_b = data_b;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            in_we_a   <= 1'b0;
            in_we_b   <= 1'b0;
            in_addr_a <= tdpr_pkg::ADDR_RESET;
            in_addr_b <= tdpr_pkg::ADDR_RESET;
            in_data_a <= tdpr_pkg::DATA_RESET;
            in_data_b <= tdpr_pkg::DATA_RESET;
        end
        else
        begin
            in_we_a   <= next_in_we_a;
            in_we_b   <= next_in_we_b;
            in_addr_a <= next_in_addr_a;
            in_addr_b <= next_in_addr_b;
            in_data_a <= next_in_data_a;
            in_data_b <= next_in_data_b;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // storage
    assign port_a.en    = gate;
    assign port_a.we    = in_we_a;
    assign port_a.addr  = in_addr_a;
    assign port_a.wdata = in_data_a;
    assign port_b.en    = gate;
    assign port_b.we    = in_we_b;
    assign port_b.addr  = in_addr_b;
    assign port_b.wdata = in_data_b;

    tdpr_mem #(
        .RELAXED    (RELAXED_COLLISION_OPTION),
        .USE_INIT   (USE_INIT),
        .INIT_IMAGE (INIT_IMAGE)
    ) u_mem (
        .clk   (clk),
        .rst_n (rst_n),
        .pa    (port_a),
        .pb    (port_b)
    );

    ////////////////////////////////////////////////////////////////////////////
    // second read register, left out in relaxed mode
    always_comb
    begin
        next_hold_a = hold_a;
        next_hold_b = hold_b;
        if (gate)
        begin
            next_hold_a = port_a.rdata;                              // RQ3
            next_hold_b = port_b.rdata;
        end
        src_a = RELAXED_COLLISION_OPTION ? port_a.rdata : hold_a;    // RQ4
        src_b = RELAXED_COLLISION_OPTION ? port_b.rdata : hold_b;
    end

    // optional output register, runs regardless of the qualifier
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hold_a <= tdpr_pkg::DATA_RESET;
            hold_b <= tdpr_pkg::DATA_RESET;
            out_a  <= tdpr_pkg::DATA_RESET;
            out_b  <= tdpr_pkg::DATA_RESET;
        end
        else
        begin
            hold_a <= next_hold_a;
            hold_b <= next_hold_b;
            out_a  <= src_a;                                         // RQ9
            out_b  <= src_b;
        end
    end

    assign q_a      = REGISTER_OUTPUT ? out_a : src_a;               // RQ2
    assign q_b      = REGISTER_OUTPUT ? out_b : src_b;
    assign q_a_sign = tdpr_pkg::is_signed(tdpr_pkg::FORMAT) & q_a[tdpr_pkg::SIGN_POS]; // RQ14
    assign q_b_sign = tdpr_pkg::is_signed(tdpr_pkg::FORMAT) & q_b[tdpr_pkg::SIGN_POS];

    ////////////////////////////////////////////////////////////////////////////
    // checks
    in_reg_a_a: assert property (@(posedge clk) disable iff (!rst_n)      // RQ2
        gate |=> (in_addr_a == $past(addr_a)) && (in_we_a == $past(wren_a)))
        else $error("port a input not registered");

    in_reg_b_a: assert property (@(posedge clk) disable iff (!rst_n)      // RQ1
        gate |=> (in_addr_b == $past(addr_b)) && (in_data_b == $past(data_b)))
        else $error("port b input not registered");

    qual_hold_a: assert property (@(posedge clk) disable iff (!rst_n)     // RQ10
        !gate |=> $stable(in_addr_a) && $stable(in_data_b) && $stable(hold_a))
        else $error("qualifier low but state moved");

    out_ungated_a: assert property (@(posedge clk) disable iff (!rst_n)   // RQ9
        (REGISTER_OUTPUT && !gate) |=> q_b == $past(src_b))
        else $error("output register stalled by qualifier");

    read_pipe_a: assert property (@(posedge clk) disable iff (!rst_n)     // RQ15
        (!RELAXED_COLLISION_OPTION && !REGISTER_OUTPUT && gate) ##1 gate
        |=> q_a == $past(port_a.rdata))
        else $error("port a read pipeline wrong");

    sign_bit_a: assert property (@(posedge clk) disable iff (!rst_n)      // RQ14
        REGISTER_OUTPUT |=> q_a_sign == (tdpr_pkg::is_signed(tdpr_pkg::FORMAT)
                                         && $past(src_a[tdpr_pkg::SIGN_POS])))
        else $error("sign flag does not follow top bit");

    in_reg_rest_a: assert property (@(posedge clk) disable iff (!rst_n)   // RQ1
        gate |=> (in_we_b == $past(wren_b)) && (in_data_a == $past(data_a)))
        else $error("remaining input registers did not capture");

    qual_hold_b_a: assert property (@(posedge clk) disable iff (!rst_n)   // RQ9
        !gate |=> $stable(in_addr_b) && $stable(in_data_a) && $stable(in_we_a)
                  && $stable(in_we_b) && $stable(hold_b))
        else $error("qualifier low but port b state moved");

    read_pipe_b_a: assert property (@(posedge clk) disable iff (!rst_n)   // RQ2
        (!RELAXED_COLLISION_OPTION && !REGISTER_OUTPUT && gate) ##1 gate
        |=> q_b == $past(port_b.rdata))
        else $error("port b read pipeline wrong");

    out_reg_both_a: assert property (@(posedge clk) disable iff (!rst_n)  // RQ2
        REGISTER_OUTPUT |=> (q_a == $past(src_a)) && (q_b == $past(src_b)))
        else $error("output register did not follow read data");

    sign_bit_b_a: assert property (@(posedge clk) disable iff (!rst_n)    // RQ14
        REGISTER_OUTPUT |=> q_b_sign == (tdpr_pkg::is_signed(tdpr_pkg::FORMAT)
                                         && $past(src_b[tdpr_pkg::SIGN_POS])))
        else $error("port b sign flag does not follow top bit");

    reset_out_a: assert property (@(posedge clk)                          // RQ2
        !rst_n |-> (q_a == tdpr_pkg::DATA_RESET) && (q_b == tdpr_pkg::DATA_RESET))
        else $error("outputs not cleared during reset");

endmodule // tdpr_top

// ===== tdpr_user.sv
// stand-in for the user datapath that drives both memory ports
`timescale 1ns/10ps
module tdpr_user (
    output logic                        ena,
    output logic [tdpr_pkg::DATA_W-1:0] data_a,
    output logic [tdpr_pkg::ADDR_W-1:0] addr_a,
    output logic                        wren_a,
    output logic [tdpr_pkg::DATA_W-1:0] data_b,
    output logic [tdpr_pkg::ADDR_W-1:0] addr_b,
    output logic                        wren_b
);

    ////////////////////////////////////////////////////////////////////////////
    // one cycle of requests on both ports
    task automatic drive(
        input logic                        en,
        input logic                        wa,
        input logic [tdpr_pkg::ADDR_W-1:0] aa,
        input logic [tdpr_pkg::DATA_W-1:0] da,
        input logic                        wb,
        input logic [tdpr_pkg::ADDR_W-1:0] ab,
        input logic [tdpr_pkg::DATA_W-1:0] db
    );
        ena    = en;
        wren_a = wa;
        addr_a = aa;
        data_a = da;
        addr_b = ab;
        data_b = db;
        wren_b = wb && !(wa && (aa == ab));
    endtask

    initial
    begin
        drive(1'b0, 1'b0, '0, '0, 1'b0, '0, '0);
    end

endmodule // tdpr_user
